// File: bench/status_flags_and_stack_test.sv
/*
  status_flags_and_stack_test: self-checking bench for the status word,
  jump conditions and stack sequencing.
  Assumes the stack memory answers combinationally from a small array.
*/
`timescale 1ns/1ps
`default_nettype none

module status_flags_and_stack_test;
  // ==========================================
  // stimulus and observed signals
  logic                            clk, rst_n, mem_wr, op_valid, op_cin, op_bit_in;
  logic                            op_jump_sel_carry, sp_load, seq_start;
  logic                            jump_taken_ff, stack_wr_ff, stack_rd_ff, seq_done_ff;
  logic [15:0]                     mem_addr, op_a, op_b, sp_load_val, ret_addr;
  logic [15:0]                     stack_addr_ff, stack_pointer_ff, pc_restore_ff;
  logic [7:0]                      mem_wdata, psw_rdata_ff, bank_base_ff, stack_wdata_ff;
  logic [7:0]                      stack_rdata;
  logic [3:0]                      op_bank_wr;
  logic [7:0]                      smem [0:255];
  status_stack_pkg::flag_op_t      op_class;
  status_stack_pkg::jump_cc_t      jump_cc;
  status_stack_pkg::stack_seq_t    seq_kind;
  int                              n_errors, samples_checked, nw, nr;

  status_flags_and_stack status_flags_and_stack_inst (
    .clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .psw_rdata_ff(psw_rdata_ff), .op_valid(op_valid),
    .op_class(op_class), .op_a(op_a), .op_b(op_b), .op_cin(op_cin),
    .op_bit_in(op_bit_in), .op_jump_sel_carry(op_jump_sel_carry),
    .op_bank_wr(op_bank_wr), .jump_cc(jump_cc), .jump_taken_ff(jump_taken_ff),
    .bank_base_ff(bank_base_ff), .sp_load(sp_load), .sp_load_val(sp_load_val),
    .seq_start(seq_start), .seq_kind(seq_kind), .ret_addr(ret_addr),
    .stack_rdata(stack_rdata), .stack_addr_ff(stack_addr_ff),
    .stack_wdata_ff(stack_wdata_ff), .stack_wr_ff(stack_wr_ff),
    .stack_rd_ff(stack_rd_ff), .stack_pointer_ff(stack_pointer_ff),
    .pc_restore_ff(pc_restore_ff), .seq_done_ff(seq_done_ff)
  );

  // ==========================================
  // stack memory
  assign stack_rdata = smem[stack_addr_ff[7:0]];

  always @(posedge clk)
  begin
    if (stack_wr_ff)
      smem[stack_addr_ff[7:0]] <= stack_wdata_ff;
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // helpers
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // one instruction, then flags {jump,zero,carry,half} under mask
  task automatic op(input status_stack_pkg::flag_op_t c, input logic [15:0] a,
                    input logic [15:0] b, input logic bi, input logic sc,
                    input logic [3:0] ef, input logic [3:0] m);
    op_class = c;
    op_a = a;
    op_b = b;
    op_bank_wr = a[3:0];
    op_bit_in = bi;
    op_jump_sel_carry = sc;
    op_valid = 1'b1;
    @(posedge clk);
    #1 op_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({12'h000, psw_rdata_ff[7:4] & m}, {12'h000, ef & m});
  endtask

  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(posedge clk);
    #1 mem_wr = 1'b0;
    mem_addr = 16'h003F;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic jc(input logic [5:0] e);
    for (int i = 0; i < 6; i++)
    begin
      jump_cc = status_stack_pkg::jump_cc_t'(3'(i));
      repeat (2) @(posedge clk);
      #1 chk({15'h0000, jump_taken_ff}, {15'h0000, e[i]});
    end
  endtask

  // runs one stack sequence, optionally raising a second start as a call while busy
  task automatic sq(input status_stack_pkg::stack_seq_t k, input logic [15:0] r,
                    input logic inj);
    logic done;
    done = 1'b0;
    nw = 0;
    nr = 0;
    seq_kind = k;
    ret_addr = r;
    seq_start = 1'b1;
    for (int i = 0; i < 20 && !done; i++)
    begin
      @(posedge clk);
      #1;
      nw += int'(stack_wr_ff);
      nr += int'(stack_rd_ff);
      done = seq_done_ff;
      seq_start = inj && i == 0;
      if (inj && i == 0)
        seq_kind = status_stack_pkg::SEQ_CALL;
    end
    if (!done)
    begin
      n_errors++;
      wrap_up();
    end
    else
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {rst_n, mem_wr, op_valid, op_cin, op_bit_in, op_jump_sel_carry} = 6'h00;
    {sp_load, seq_start, mem_wdata, op_bank_wr} = 14'h0000;
    {op_a, op_b, sp_load_val, ret_addr} = 64'h0;
    mem_addr = 16'h003F;
    op_class = status_stack_pkg::OP_NONE;
    jump_cc = status_stack_pkg::CC_TRUE;
    seq_kind = status_stack_pkg::SEQ_CALL;
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({8'h00, psw_rdata_ff & 8'h8F}, 16'h0080);
    chk({8'h00, bank_base_ff}, 16'h0040);
    op(status_stack_pkg::OP_ADD8, 16'h0019, 16'h0028, 1'b0, 1'b1, 4'h1, 4'hF);
    mw(16'h003F, 8'hF5);
    chk({8'h00, psw_rdata_ff}, 16'h0095);
    chk({8'h00, bank_base_ff}, 16'h0068);
    mw(16'h0040, 8'h0A);
    chk({8'h00, psw_rdata_ff}, 16'h0095);
    op(status_stack_pkg::OP_ADD8, 16'h00FF, 16'h0001, 1'b0, 1'b0, 4'hF, 4'hF);
    op(status_stack_pkg::OP_SUB8, 16'h0010, 16'h0001, 1'b0, 1'b1, 4'h1, 4'hF);
    op(status_stack_pkg::OP_SUB8, 16'h0000, 16'h0001, 1'b0, 1'b1, 4'hB, 4'hF);
    op(status_stack_pkg::OP_ADD16, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 4'hE, 4'hE);
    op(status_stack_pkg::OP_ADD16, 16'h0100, 16'h0100, 1'b0, 1'b0, 4'h0, 4'hE);
    op(status_stack_pkg::OP_BITMOD, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'hC, 4'hC);
    op(status_stack_pkg::OP_BITMOD, 16'h0000, 16'h0000, 1'b1, 1'b0, 4'h0, 4'hC);
    op(status_stack_pkg::OP_MUL, 16'h0010, 16'h000F, 1'b0, 1'b0, 4'h4, 4'h4);
    op(status_stack_pkg::OP_MUL, 16'h0010, 16'h0010, 1'b0, 1'b0, 4'h0, 4'h4);
    op(status_stack_pkg::OP_DIV, 16'h1234, 16'h0000, 1'b0, 1'b0, 4'h2, 4'h2);
    op(status_stack_pkg::OP_DIV, 16'h0100, 16'h0001, 1'b0, 1'b0, 4'h6, 4'h6);
    op(status_stack_pkg::OP_DIV, 16'h00FF, 16'h0010, 1'b0, 1'b0, 4'h0, 4'h6);
    op(status_stack_pkg::OP_SHIFT_C, 16'h0000, 16'h0000, 1'b1, 1'b0, 4'h2, 4'h2);
    op(status_stack_pkg::OP_SHIFT_C, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0, 4'h2);
    op(status_stack_pkg::OP_CARRY_SET, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h2, 4'h2);
    op(status_stack_pkg::OP_CARRY_CPL, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0, 4'h2);
    op(status_stack_pkg::OP_CARRY_CPL, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h2, 4'h2);
    op(status_stack_pkg::OP_CARRY_CLR, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'h0, 4'h2);
    op(status_stack_pkg::OP_CARRY_LD, 16'h0000, 16'h0000, 1'b1, 1'b0, 4'h2, 4'h2);
    op(status_stack_pkg::OP_LOAD, 16'h0000, 16'h0000, 1'b0, 1'b0, 4'hC, 4'hC);
    op(status_stack_pkg::OP_LOAD, 16'h0005, 16'h0000, 1'b0, 1'b0, 4'h8, 4'hC);
    op(status_stack_pkg::OP_PSW_WR, 16'h0009, 16'h0000, 1'b0, 1'b0, 4'hA, 4'hE);
    chk({12'h000, psw_rdata_ff[3:0]}, 16'h0009);
    op(status_stack_pkg::OP_ADD8, 16'h0000, 16'h0000, 1'b0, 1'b1, 4'h4, 4'hF);
    jc(6'b100110);
    op(status_stack_pkg::OP_ADD8, 16'h00F0, 16'h0020, 1'b0, 1'b1, 4'hA, 4'hF);
    jc(6'b011001);
    // pointer loaded before any stack use
    sp_load_val = 16'h043F;
    sp_load = 1'b1;
    @(posedge clk);
    #1 sp_load = 1'b0;
    @(posedge clk);
    #1 chk(stack_pointer_ff, 16'h043F);
    sq(status_stack_pkg::SEQ_CALL, 16'h1234, 1'b0);
    chk(16'(nw), 16'h0002);
    chk({smem[8'h3F], smem[8'h3E]}, 16'h1234);
    chk(stack_pointer_ff, 16'h043D);
    sq(status_stack_pkg::SEQ_RET, 16'h0000, 1'b0);
    chk(16'(nr), 16'h0002);
    chk(pc_restore_ff, 16'h1234);
    chk(stack_pointer_ff, 16'h043F);
    op(status_stack_pkg::OP_ADD8, 16'h0008, 16'h0008, 1'b0, 1'b1, 4'h1, 4'hF);
    op(status_stack_pkg::OP_PSW_WR, 16'h0006, 16'h0000, 1'b0, 1'b0, 4'h9, 4'hF);
    sq(status_stack_pkg::SEQ_INT, 16'hABCD, 1'b1);
    chk(16'(nw), 16'h0003);
    chk({8'h00, smem[8'h3F]}, 16'h0096);
    chk({smem[8'h3E], smem[8'h3D]}, 16'hABCD);
    chk(stack_pointer_ff, 16'h043C);
    op(status_stack_pkg::OP_PSW_WR, 16'h0009, 16'h0000, 1'b0, 1'b0, 4'h9, 4'hF);
    op(status_stack_pkg::OP_ADD8, 16'h00FF, 16'h0001, 1'b0, 1'b0, 4'hF, 4'hF);
    sq(status_stack_pkg::SEQ_MASKABLE_INT_RETURN, 16'h0000, 1'b0);
    chk(16'(nr), 16'h0003);
    chk(pc_restore_ff, 16'hABCD);
    chk(stack_pointer_ff, 16'h043F);
    chk({8'h00, psw_rdata_ff}, 16'h0096);
    chk({8'h00, bank_base_ff}, 16'h0070);
    wrap_up();
  end
endmodule // status_flags_and_stack_test

`default_nettype wire

// File: logic/status_flags_and_stack.sv
/*
  status_flags_and_stack: status word (bank selector and four flags),
  jump condition evaluation and stack pointer with call, interrupt and
  return byte sequencing. Assumes the decoder gives one flag class
  pulse per executed instruction and that the stack memory port
  accepts one byte per clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: status word at 003F, bank low, flags high
// RQ2: memory writes change bank selector only (code also sets the jump flag)
// RQ3: instruction write to status sets jump flag
// RQ4: four-bit bank selector, reset clears it
// RQ5: reset sets jump flag, others untouched
// RQ6: zero flag on zero result or byte
// RQ7: bit set/clear/complement: zero means bit was 0
// RQ8: multiply high byte, divide remainder set zero
// RQ9: carry on add carry-out or subtract borrow
// RQ10: divide carry on zero divisor or overflow
// RQ11: through-carry shifts load shifted-out bit
// RQ12: carry is boolean accumulator, set/clear/complement
// RQ13: half carry from bit 3 into 4
// RQ14: arithmetic loads jump flag from outcome
// RQ15: true jump on flag 1, false on 0
// RQ16: load/exchange/jump class sets jump flag
// RQ17: zero, carry, jump testable; half carry not
// RQ18: interrupt pushes status, high, low; call two bytes
// RQ19: interrupt return pops low, high, status
// RQ20: store then decrement; increment then read
// RQ21: stack pointer has no reset value
// RQ22: sixteen banks of eight registers each
// RQ23: jump bit7, zero bit6, carry bit5, half bit4
module status_flags_and_stack (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // memory-mapped special register access
  input  wire logic [15:0]                     mem_addr,
  input  wire logic                            mem_wr,
  input  wire logic [7:0]                      mem_wdata,
  output logic      [7:0]                      psw_rdata_ff,
  // flag update from the executing instruction
  input  wire logic                            op_valid,
  input  wire status_stack_pkg::flag_op_t      op_class,
  input  wire logic [15:0]                     op_a,
  input  wire logic [15:0]                     op_b,
  input  wire logic                            op_cin,
  input  wire logic                            op_bit_in,
  input  wire logic                            op_jump_sel_carry,
  input  wire logic [3:0]                      op_bank_wr,
  // condition test and bank base
  input  wire status_stack_pkg::jump_cc_t      jump_cc,
  output logic                                 jump_taken_ff,
  output logic      [7:0]                      bank_base_ff,
  // stack control
  input  wire logic                            sp_load,
  input  wire logic [15:0]                     sp_load_val,
  input  wire logic                            seq_start,
  input  wire status_stack_pkg::stack_seq_t    seq_kind,
  input  wire logic [15:0]                     ret_addr,
  input  wire logic [7:0]                      stack_rdata,
  // stack memory port and results
  output logic      [15:0]                     stack_addr_ff,
  output logic      [7:0]                      stack_wdata_ff,
  output logic                                 stack_wr_ff,
  output logic                                 stack_rd_ff,
  output logic      [15:0]                     stack_pointer_ff,
  output logic      [15:0]                     pc_restore_ff,
  output logic                                 seq_done_ff
);

  // ==========================================================
  // status word
  logic [3:0] bank_selector_ff;
  logic       zero_flag_ff;
  logic       carry_flag_ff;
  logic       half_carry_flag_ff;
  logic       jump_status_flag_ff;

  // RQ1 status word decode
  wire psw_hit = (mem_addr == status_stack_pkg::PSW_ADDR);
  // RQ23 flag placement
  wire [7:0] psw_word = {jump_status_flag_ff, zero_flag_ff, carry_flag_ff,
                         half_carry_flag_ff, bank_selector_ff};

  // ==========================================================
  // flag arithmetic
  wire [8:0]  add8 = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]} + {8'h00, op_cin};
  wire [8:0]  sub8 = {1'b0, op_a[7:0]} - {1'b0, op_b[7:0]} - {8'h00, op_cin};
  wire [4:0]  add4 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, op_cin};
  wire [4:0]  sub4 = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, op_cin};
  wire [16:0] add16 = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, op_cin};
  wire [16:0] sub16 = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, op_cin};
  wire [15:0] prod = op_a[7:0] * op_b[7:0];
  wire        div_zero = (op_b[7:0] == 8'h00);
  wire [15:0] quot = div_zero ? 16'hFFFF : op_a / {8'h00, op_b[7:0]};
  wire [15:0] rem16 = div_zero ? op_a : op_a % {8'h00, op_b[7:0]};

  logic nxt_zero;
  logic nxt_carry;
  logic nxt_half;
  logic nxt_jump;
  logic arith_op;

  always_comb
  begin
    nxt_zero = zero_flag_ff;
    nxt_carry = carry_flag_ff;
    nxt_half = half_carry_flag_ff;
    nxt_jump = jump_status_flag_ff;
    arith_op = 1'b0;
    case (op_class)
      status_stack_pkg::OP_ADD8:
      begin
        // RQ6 RQ9 RQ13 eight-bit add
        nxt_zero = (add8[7:0] == 8'h00);
        nxt_carry = add8[8];
        nxt_half = add4[4];
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_SUB8:
      begin
        // RQ9 RQ13 borrow out
        nxt_zero = (sub8[7:0] == 8'h00);
        nxt_carry = sub8[8];
        nxt_half = sub4[4];
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_ADD16:
      begin
        // RQ6 sixteen-bit zero
        nxt_zero = (add16[15:0] == 16'h0000);
        nxt_carry = add16[16];
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_SUB16:
      begin
        nxt_zero = (sub16[15:0] == 16'h0000);
        nxt_carry = sub16[16];
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_LOGIC:
      begin
        nxt_zero = (op_a[7:0] == 8'h00);
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_LOAD:
      begin
        // RQ16 transfer sets jump flag
        nxt_zero = (op_a[7:0] == 8'h00);
        nxt_jump = 1'b1;
      end
      status_stack_pkg::OP_BITMOD:
      begin
        // RQ7 old bit value
        nxt_zero = ~op_bit_in;
        nxt_jump = ~op_bit_in;
      end
      status_stack_pkg::OP_MUL:
      begin
        // RQ8 product high byte
        nxt_zero = (prod[15:8] == 8'h00);
        nxt_jump = nxt_zero;
      end
      status_stack_pkg::OP_DIV:
      begin
        // RQ8 RQ10 remainder and overflow
        nxt_zero = (rem16[7:0] == 8'h00);
        nxt_carry = div_zero | (quot[15:8] != 8'h00);
        arith_op = 1'b1;
      end
      status_stack_pkg::OP_SHIFT_C:
      begin
        // RQ11 shifted-out bit
        nxt_carry = op_bit_in;
        nxt_jump = op_bit_in;
      end
      // RQ12 boolean accumulator
      status_stack_pkg::OP_CARRY_SET: nxt_carry = 1'b1;
      status_stack_pkg::OP_CARRY_CLR: nxt_carry = 1'b0;
      status_stack_pkg::OP_CARRY_CPL: nxt_carry = ~carry_flag_ff;
      status_stack_pkg::OP_CARRY_LD:  nxt_carry = op_bit_in;
      // RQ3 instruction write of status
      status_stack_pkg::OP_PSW_WR:    nxt_jump = 1'b1;
      default:                        nxt_jump = jump_status_flag_ff;
    endcase
    // RQ14 jump flag takes outcome
    if (arith_op)
    begin
      nxt_jump = op_jump_sel_carry ? nxt_carry : nxt_zero;
    end
  end

  // stack sequencer state, also read by the status word restore
  status_stack_pkg::stack_state_t st_ff;
  status_stack_pkg::stack_seq_t   kind_ff;
  logic [1:0]                     cnt_ff;
  logic [1:0]                     pop_sel_ff;
  logic [15:0]                    sp_ff;

  // RQ19 status word is the last pop
  wire pop_psw = stack_rd_ff && (pop_sel_ff == 2'd0)
                 && (kind_ff == status_stack_pkg::SEQ_MASKABLE_INT_RETURN);
  // RQ2 memory write loads bank selector and sets jump flag
  wire mem_bank_wr = mem_wr & psw_hit;
  wire op_bank = op_valid & (op_class == status_stack_pkg::OP_PSW_WR);

  // RQ4 RQ5 reset values; other flags hold
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_selector_ff <= status_stack_pkg::BANK_RST;
      jump_status_flag_ff <= status_stack_pkg::JUMP_RST;
    end
    else if (pop_psw)
    begin
      bank_selector_ff <= stack_rdata[3:0];
      jump_status_flag_ff <= stack_rdata[status_stack_pkg::JUMP_BIT];
    end
    else
    begin
      if (op_bank)
        bank_selector_ff <= op_bank_wr;
      else if (mem_bank_wr)
        bank_selector_ff <= mem_wdata[3:0];
      if (op_valid)
        jump_status_flag_ff <= nxt_jump;
      else if (mem_bank_wr)
        jump_status_flag_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (pop_psw)
    begin
      zero_flag_ff <= stack_rdata[status_stack_pkg::ZERO_BIT];
      carry_flag_ff <= stack_rdata[status_stack_pkg::CARRY_BIT];
      half_carry_flag_ff <= stack_rdata[status_stack_pkg::HALF_BIT];
    end
    else if (op_valid)
    begin
      zero_flag_ff <= nxt_zero;
      carry_flag_ff <= nxt_carry;
      half_carry_flag_ff <= nxt_half;
    end
  end

  // ==========================================================
  // jump condition and bank base
  logic nxt_taken;
  always_comb
  begin
    // RQ15 RQ17 condition select, no half carry
    case (jump_cc)
      status_stack_pkg::CC_TRUE:  nxt_taken = jump_status_flag_ff;
      status_stack_pkg::CC_FALSE: nxt_taken = ~jump_status_flag_ff;
      status_stack_pkg::CC_ZERO:  nxt_taken = zero_flag_ff;
      status_stack_pkg::CC_NZERO: nxt_taken = ~zero_flag_ff;
      status_stack_pkg::CC_CARRY: nxt_taken = carry_flag_ff;
      status_stack_pkg::CC_NCARY: nxt_taken = ~carry_flag_ff;
      default:                    nxt_taken = 1'b0;
    endcase
  end

  // RQ22 bank base in data memory
  wire [7:0] nxt_bank_base = status_stack_pkg::BANK_BASE[7:0]
                             + {1'b0, bank_selector_ff, 3'b000};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psw_rdata_ff <= 8'h00;
      jump_taken_ff <= 1'b0;
      bank_base_ff <= 8'h00;
    end
    else
    begin
      psw_rdata_ff <= psw_hit ? psw_word : 8'h00;
      jump_taken_ff <= nxt_taken;
      bank_base_ff <= nxt_bank_base;
    end
  end

  // ==========================================================
  // stack sequencer
  // RQ19 read data stands in the same cycle as its address
  wire [1:0] low_sel  = (kind_ff == status_stack_pkg::SEQ_MASKABLE_INT_RETURN) ? 2'd2 : 2'd1;
  wire       pop_low  = stack_rd_ff && (pop_sel_ff == low_sel);
  wire       pop_high = stack_rd_ff && (pop_sel_ff == (low_sel - 2'd1));

  wire        is_push = ~seq_kind[1];
  wire [1:0]  seq_len = seq_kind[0] ? 2'd2 : 2'd1;
  // RQ18 push order status, high, low
  wire [7:0]  push_byte = (cnt_ff == 2'd2) ? psw_word :
                          (cnt_ff == 2'd1) ? ret_addr[15:8] : ret_addr[7:0];
  wire [15:0] sp_inc = sp_ff + 16'h0001;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= status_stack_pkg::ST_IDLE;
      kind_ff <= status_stack_pkg::SEQ_CALL;
      cnt_ff <= 2'd0;
      pop_sel_ff <= 2'd0;
      stack_wr_ff <= 1'b0;
      stack_rd_ff <= 1'b0;
      seq_done_ff <= 1'b0;
      stack_addr_ff <= 16'h0000;
      stack_wdata_ff <= 8'h00;
      pc_restore_ff <= 16'h0000;
    end
    else
    begin
      stack_wr_ff <= 1'b0;
      stack_rd_ff <= 1'b0;
      seq_done_ff <= 1'b0;
      case (st_ff)
        status_stack_pkg::ST_IDLE:
          if (seq_start)
          begin
            kind_ff <= seq_kind;
            cnt_ff <= seq_len;
            st_ff <= is_push ? status_stack_pkg::ST_PUSH : status_stack_pkg::ST_POP;
          end
        status_stack_pkg::ST_PUSH:
        begin
          // RQ20 store at pointer, then decrement
          stack_addr_ff <= sp_ff;
          stack_wdata_ff <= push_byte;
          stack_wr_ff <= 1'b1;
          cnt_ff <= cnt_ff - 2'd1;
          if (cnt_ff == 2'd0)
          begin
            st_ff <= status_stack_pkg::ST_IDLE;
            seq_done_ff <= 1'b1;
          end
        end
        status_stack_pkg::ST_POP:
        begin
          // RQ19 RQ20 increment, read low, high, status
          stack_addr_ff <= sp_inc;
          stack_rd_ff <= 1'b1;
          pop_sel_ff <= cnt_ff;
          cnt_ff <= cnt_ff - 2'd1;
          if (cnt_ff == 2'd0)
            st_ff <= status_stack_pkg::ST_IDLE;
        end
        default: st_ff <= status_stack_pkg::ST_IDLE;
      endcase
      // popped byte taken in the cycle its read strobe is high
      if (pop_low)
        pc_restore_ff[7:0] <= stack_rdata;
      if (pop_high)
        pc_restore_ff[15:8] <= stack_rdata;
      if (stack_rd_ff && (pop_sel_ff == 2'd0))
        seq_done_ff <= 1'b1;
    end
  end

  // RQ21 pointer has no reset value
  always_ff @(posedge clk)
  begin
    if (sp_load)
      sp_ff <= sp_load_val;
    else if (st_ff == status_stack_pkg::ST_PUSH)
      sp_ff <= sp_ff - 16'h0001;
    else if (st_ff == status_stack_pkg::ST_POP)
      sp_ff <= sp_inc;
  end

  always_ff @(posedge clk)
  begin
    stack_pointer_ff <= sp_ff;
  end

  // ==========================================================
  // checks
  // RQ5 jump flag after reset
  a_jump_reset: assert property (@(posedge clk) $rose(rst_n) |-> jump_status_flag_ff) // RQ5
    else $error("jump flag not set after reset");

  // RQ2 flags ignore memory data
  a_mem_flags: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    (mem_bank_wr && !op_valid && !pop_psw) |=> $stable(carry_flag_ff) && jump_status_flag_ff)
    else $error("memory write disturbed flags");

  // RQ3 instruction write sets jump flag, keeps the other flags
  a_psw_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    (op_bank && !pop_psw) |=> jump_status_flag_ff && $stable(zero_flag_ff)
      && $stable(carry_flag_ff) && $stable(half_carry_flag_ff))
    else $error("status write disturbed flags");

  // RQ15 true condition follows jump flag
  a_true_jump: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    (jump_cc == status_stack_pkg::CC_TRUE) |=> jump_taken_ff == $past(jump_status_flag_ff))
    else $error("true jump mismatch");

  // RQ15 false condition inverts jump flag
  a_false_jump: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    (jump_cc == status_stack_pkg::CC_FALSE) |=> jump_taken_ff == !$past(jump_status_flag_ff))
    else $error("false jump mismatch");

  // RQ20 pointer drops once per pushed byte
  a_sp_push: assert property (@(posedge clk) disable iff (!rst_n) // RQ20
    ((st_ff == status_stack_pkg::ST_PUSH) && !sp_load) |=> sp_ff == $past(sp_ff) - 16'h0001)
    else $error("pointer not decremented on push");

  sequence s_int_start;
    (st_ff == status_stack_pkg::ST_IDLE) && seq_start
      && (seq_kind == status_stack_pkg::SEQ_INT);
  endsequence

  sequence s_call_start;
    (st_ff == status_stack_pkg::ST_IDLE) && seq_start
      && (seq_kind == status_stack_pkg::SEQ_CALL);
  endsequence

  sequence s_two_bytes;
    stack_wr_ff [*2] ##1 !stack_wr_ff;
  endsequence

  sequence s_three_bytes;
    stack_wr_ff [*3] ##1 !stack_wr_ff;
  endsequence

  // RQ18 interrupt stores three bytes
  a_int_push: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    s_int_start |=> ##1 s_three_bytes)
    else $error("interrupt push not three bytes");

  // RQ18 status word stored first
  a_int_status: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    s_int_start |=> ##1 (stack_wdata_ff == $past(psw_word)))
    else $error("interrupt push not status first");

  // RQ18 call stores two bytes
  a_call_push: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    s_call_start |=> ##1 s_two_bytes)
    else $error("call push not two bytes");

endmodule // status_flags_and_stack

`default_nettype wire

// File: pkg/status_stack_pkg.sv
/*
  status_stack_pkg: addresses, field positions, reset values and
  operation codes for the core status word and stack pointer block.
  Assumes the core's memory path and instruction decoder drive the
  block on the same clock.
*/
`default_nettype none

package status_stack_pkg;

  // ==========================================================
  // memory map and field layout
  localparam logic [15:0] PSW_ADDR      = 16'h003F;
  localparam int          BANK_LSB      = 0;
  localparam int          BANK_W        = 4;
  localparam int          HALF_BIT      = 4;
  localparam int          CARRY_BIT     = 5;
  localparam int          ZERO_BIT      = 6;
  localparam int          JUMP_BIT      = 7;
  localparam logic [3:0]  BANK_RST      = 4'h0;
  localparam logic        JUMP_RST      = 1'b1;
  localparam logic [15:0] BANK_BASE     = 16'h0040;
  localparam int          BANK_REGS     = 8;
  localparam int          BANK_SHIFT    = 3;

  // ==========================================================
  // flag update class of the instruction in execution
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_ADD8      = 4'h1,
    OP_SUB8      = 4'h2,
    OP_ADD16     = 4'h3,
    OP_SUB16     = 4'h4,
    OP_LOGIC     = 4'h5,
    OP_LOAD      = 4'h6,
    OP_BITMOD    = 4'h7,
    OP_MUL       = 4'h8,
    OP_DIV       = 4'h9,
    OP_SHIFT_C   = 4'hA,
    OP_CARRY_SET = 4'hB,
    OP_CARRY_CLR = 4'hC,
    OP_CARRY_CPL = 4'hD,
    OP_CARRY_LD  = 4'hE,
    OP_PSW_WR    = 4'hF
  } flag_op_t;

  // jump condition codes
  typedef enum logic [2:0] {
    CC_TRUE  = 3'h0,
    CC_FALSE = 3'h1,
    CC_ZERO  = 3'h2,
    CC_NZERO = 3'h3,
    CC_CARRY = 3'h4,
    CC_NCARY = 3'h5
  } jump_cc_t;

  // stack sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_POP  = 3'h2
  } stack_state_t;

  typedef enum logic [1:0] {
    SEQ_CALL = 2'h0,
    SEQ_INT  = 2'h1,
    SEQ_RET  = 2'h2,
    SEQ_MASKABLE_INT_RETURN = 2'h3
  } stack_seq_t;

endpackage

`default_nettype wire
